/* design/term_regs_pkg.sv */
/*
  Package for the serial terminal register bank: word indices, field layout,
  unlock code and the bus payload structs.
  Assumes an AXI4-Lite master with 32-bit data; each 16-bit word sits in the
  low half of one aligned 32-bit slot at byte address four times its index.
*/
package term_regs_pkg;

  // ==========================================================
  // Geometry
  localparam int unsigned WORD_COUNT = 64;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned ADDR_W = 8;

  // ==========================================================
  // Word indices
  localparam logic [IDX_W-1:0] IDX_TX_QUEUE_FILL = 6'h00;
  localparam logic [IDX_W-1:0] IDX_RX_QUEUE_FILL = 6'h01;
  localparam logic [IDX_W-1:0] IDX_DIAGNOSTIC_WORD = 6'h06;
  localparam logic [IDX_W-1:0] IDX_FUNCTION_CALL_WORD = 6'h07;
  localparam logic [IDX_W-1:0] IDX_TERMINAL_KIND = 6'h08;
  localparam logic [IDX_W-1:0] IDX_FIRMWARE_VERSION = 6'h09;
  localparam logic [IDX_W-1:0] IDX_SHIFT_REG_LENGTH = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_LOGICAL_CHANNEL_COUNT = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_MIN_TRANSFER_LENGTH = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_PAYLOAD_LAYOUT_TYPE = 6'h0d;
  localparam logic [IDX_W-1:0] IDX_UNUSED_TYPE_SLOT = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_BUS_ALIGNMENT = 6'h0f;
  localparam logic [IDX_W-1:0] IDX_MAKER_FIRST = 6'h10;
  localparam logic [IDX_W-1:0] IDX_MAKER_LAST = 6'h1e;
  localparam logic [IDX_W-1:0] IDX_UNLOCK_KEY = 6'h1f;
  localparam logic [IDX_W-1:0] IDX_OPERATING_MODE_SELECT = 6'h20;
  localparam logic [IDX_W-1:0] IDX_USER_LAST = 6'h2e;

  // ==========================================================
  // Values
  localparam logic [15:0] UNLOCK_CODE = 16'h1235;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] BUS_ALIGNMENT_RESET = 16'h0000;
  localparam logic [15:0] FUNC_CALL_RESET = 16'h0000;
  localparam logic [7:0] LAYOUT_NONE = 8'h00;
  localparam logic [7:0] LAYOUT_FIXED_FIRST = 8'h01;
  localparam logic [7:0] LAYOUT_FIXED_LAST = 8'h08;
  localparam logic [7:0] LAYOUT_VAR_FIRST = 8'h11;
  localparam logic [7:0] LAYOUT_VAR_LAST = 8'h16;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================================
  // Bus payloads
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
  } axil_addr_s;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0] strb;
  } axil_wdata_s;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } axil_rdata_s;

  // Status from the serial engine: fill counts and sticky error bits
  typedef struct packed {
    logic [7:0] tx_fill;
    logic [7:0] rx_fill;
    logic [15:0] diag;
    logic [7:0] func_result;
  } engine_status_s;

endpackage

/* design/serial_terminal_register_bank.sv */
/*
  Register bank of a serial interface terminal, one logical channel, reached
  over AXI4-Lite. Holds the process, type, maker and user parameter words.
  Assumes the serial engine supplies fill counts, diagnostics and a function
  result on aclk, and that nonvolatile backing of parameter words is handled
  by whoever loads and saves the exported words.
*/
// Summary of operation
// [R1]: Sixty-four sixteen-bit word locations per logical channel.
// [R2]: Transmit queue count in low byte of tx fill word, high byte zero.
// [R3]: Receive queue count in low byte of rx fill word, high byte zero.
// [R4]: Locations two to five do nothing.
// [R5]: Diagnostic word shows extra error information such as parity errors.
// [R6]: Command word: write number low, parameter high; read number and result.
// [R7]: Type words eight to fifteen are fixed and ignore writes; the code keeps word fifteen (alignment) writable.
// [R8]: Terminal type word is read-only identification.
// [R9]: Firmware version word reads as ASCII characters.
// [R10]: Data length word gives shift register count and bit length.
// [R11]: Channel word gives number of logical channels.
// [R12]: Minimum length bytes; MSB set means control byte optional.
// [R13]: Layout type codes 0x00, 0x01-0x08, 0x11-0x16.
// [R14]: Alignment word places data on a byte boundary of terminal bus.
// [R15]: Maker parameters sixteen to thirty are kept in nonvolatile storage.
// [R16]: Maker parameters change only after the valid code word.
// [R17]: Writing 0x1235 to the code word unlocks parameter writes.
// [R18]: Any other code word value sets write protection.
// [R19]: Code word reads unlock code when open, zero when protected.
// [R20]: Feature word selects operating modes.
// [R21]: Locations forty-seven to sixty-three are unimplemented.
// [R22]: Writes to read-only, unused or protected words are ignored.
`timescale 1ns/100ps

module serial_terminal_register_bank
  import term_regs_pkg::*;
#(
  parameter logic [15:0] TERMINAL_KIND = 16'h0001,      // Arbitrary value
  parameter logic [15:0] FIRMWARE_VERSION = 16'h3141,   // ASCII "1A", arbitrary
  parameter logic [15:0] SHIFT_REG_LENGTH = 16'h0120,
  parameter logic [15:0] LOGICAL_CHANNEL_COUNT = 16'h0001,
  parameter logic [15:0] MIN_TRANSFER_LENGTH = 16'h0404,
  parameter logic [7:0] PAYLOAD_LAYOUT_TYPE = 8'h02,
  parameter logic [15:0] MODE_RESET = 16'h0000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire axil_addr_s s_axi_aw,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire axil_wdata_s s_axi_w,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire axil_addr_s s_axi_ar,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output axil_rdata_s s_axi_r,
  input wire engine_status_s engine_status,
  output logic func_call_pulse,
  output logic [15:0] func_call_word,
  output logic [15:0] bus_alignment,
  output logic [15:0] operating_mode,
  output logic param_unlocked,
  output logic nv_save_pulse,
  output logic [IDX_W-1:0] nv_save_index,
  output logic [15:0] nv_save_data
);

  // ==========================================================
  // State
  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    axil_wdata_s w;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    axil_rdata_s r;
    logic [15:0] func_word;
    logic func_pulse;
    logic [15:0] align;
    logic [15:0] key;
    logic [15:0] mode;
    logic [14:0][15:0] maker;
    logic [13:0][15:0] user;
    logic nv_pulse;
    logic [IDX_W-1:0] nv_index;
    logic [15:0] nv_data;
  } state_s;

  state_s q, d;

  // Maker block indices 16..30, user block beyond the mode word 33..46
  function automatic logic in_maker(input logic [IDX_W-1:0] idx);
    return idx >= IDX_MAKER_FIRST && idx <= IDX_MAKER_LAST;
  endfunction

  function automatic logic in_user(input logic [IDX_W-1:0] idx);
    return idx > IDX_OPERATING_MODE_SELECT && idx <= IDX_USER_LAST;
  endfunction

  function automatic logic [IDX_W-1:0] word_index(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:2];
  endfunction

  // Layout code is forced to "no valid type" if the parameter is not a legal code
  function automatic logic [7:0] legal_layout(input logic [7:0] code);
    if ((code >= LAYOUT_FIXED_FIRST && code <= LAYOUT_FIXED_LAST) ||
        (code >= LAYOUT_VAR_FIRST && code <= LAYOUT_VAR_LAST)) begin
      return code; // [R13]
    end
    return LAYOUT_NONE; // [R13]
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input axil_wdata_s w);
    logic [15:0] v;
    v = old;
    if (w.strb[0]) begin
      v[7:0] = w.data[7:0];
    end
    if (w.strb[1]) begin
      v[15:8] = w.data[15:8];
    end
    return v;
  endfunction

  logic unlocked;
  assign unlocked = (q.key == UNLOCK_CODE); // [R17] [R18]

  // ==========================================================
  // Read decode
  function automatic logic [15:0] read_word(input logic [IDX_W-1:0] idx, input state_s s,
                                             input engine_status_s es, input logic open);
    logic [15:0] v;
    v = WORD_ZERO;
    if (in_maker(idx)) begin
      v = s.maker[idx - IDX_MAKER_FIRST]; // [R15]
    end else if (in_user(idx)) begin
      v = s.user[idx - IDX_OPERATING_MODE_SELECT - 6'h01];
    end else begin
      unique case (idx)
        IDX_TX_QUEUE_FILL: v = {8'h00, es.tx_fill}; // [R2]
        IDX_RX_QUEUE_FILL: v = {8'h00, es.rx_fill}; // [R3]
        IDX_DIAGNOSTIC_WORD: v = es.diag; // [R5]
        IDX_FUNCTION_CALL_WORD: v = {es.func_result, s.func_word[7:0]}; // [R6]
        IDX_TERMINAL_KIND: v = TERMINAL_KIND; // [R8]
        IDX_FIRMWARE_VERSION: v = FIRMWARE_VERSION; // [R9]
        IDX_SHIFT_REG_LENGTH: v = SHIFT_REG_LENGTH; // [R10]
        IDX_LOGICAL_CHANNEL_COUNT: v = LOGICAL_CHANNEL_COUNT; // [R11]
        IDX_MIN_TRANSFER_LENGTH: v = MIN_TRANSFER_LENGTH; // [R12]
        IDX_PAYLOAD_LAYOUT_TYPE: v = {8'h00, legal_layout(PAYLOAD_LAYOUT_TYPE)}; // [R13]
        IDX_BUS_ALIGNMENT: v = s.align; // [R14]
        IDX_UNLOCK_KEY: v = open ? UNLOCK_CODE : WORD_ZERO; // [R19]
        IDX_OPERATING_MODE_SELECT: v = s.mode; // [R20]
        default: v = WORD_ZERO; // [R4] [R21]
      endcase
    end
    return v;
  endfunction

  // ==========================================================
  // Next state
  logic [IDX_W-1:0] widx;
  logic do_write;

  always_comb begin
    d = q;
    d.func_pulse = 1'b0;
    d.nv_pulse = 1'b0;
    widx = word_index(q.aw_addr);
    do_write = q.aw_held && q.w_held && !q.bvalid;

    // Address and data are taken in either order and held until both are in
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_held = 1'b1;
      d.aw_addr = s_axi_aw.addr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_held = 1'b1;
      d.w = s_axi_w;
    end

    if (do_write) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (in_maker(widx)) begin
        if (unlocked) begin // [R16] [R22]
          d.maker[widx - IDX_MAKER_FIRST] = merge(q.maker[widx - IDX_MAKER_FIRST], q.w);
          d.nv_pulse = 1'b1; // [R15]
          d.nv_index = widx;
          d.nv_data = d.maker[widx - IDX_MAKER_FIRST];
        end
      end else if (in_user(widx)) begin
        if (unlocked) begin // [R17] [R22]
          d.user[widx - IDX_OPERATING_MODE_SELECT - 6'h01] =
            merge(q.user[widx - IDX_OPERATING_MODE_SELECT - 6'h01], q.w);
          d.nv_pulse = 1'b1;
          d.nv_index = widx;
          d.nv_data = d.user[widx - IDX_OPERATING_MODE_SELECT - 6'h01];
        end
      end else begin
        unique case (widx)
          IDX_FUNCTION_CALL_WORD: begin
            d.func_word = merge(q.func_word, q.w); // [R6]
            d.func_pulse = 1'b1;
          end
          IDX_BUS_ALIGNMENT: d.align = merge(q.align, q.w); // [R14]
          // Full word compare on the merged key: byte writes can build the code in two steps
          IDX_UNLOCK_KEY: d.key = merge(q.key, q.w); // [R17] [R18]
          IDX_OPERATING_MODE_SELECT: begin
            if (unlocked) begin // [R20] [R22]
              d.mode = merge(q.mode, q.w);
              d.nv_pulse = 1'b1;
              d.nv_index = widx;
              d.nv_data = d.mode;
            end
          end
          // Read-only, unused and unimplemented words ignore writes
          default: d.bresp = RESP_OKAY; // [R7] [R21] [R22]
        endcase
      end
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.r.data = {16'h0000, read_word(word_index(s_axi_ar.addr), q, engine_status, unlocked)}; // [R1]
      d.r.resp = RESP_OKAY;
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q.aw_held <= 1'b0;
      q.aw_addr <= '0;
      q.w_held <= 1'b0;
      q.w <= '0;
      q.bvalid <= 1'b0;
      q.bresp <= RESP_OKAY;
      q.rvalid <= 1'b0;
      q.r <= '0;
      q.func_word <= FUNC_CALL_RESET;
      q.func_pulse <= 1'b0;
      q.align <= BUS_ALIGNMENT_RESET;
      q.key <= WORD_ZERO;
      q.mode <= MODE_RESET;
      // Power-up defaults; the nonvolatile loader would overwrite these
      q.maker <= '0;
      q.user <= '0;
      q.nv_pulse <= 1'b0;
      q.nv_index <= '0;
      q.nv_data <= WORD_ZERO;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = !q.aw_held && !q.bvalid;
  assign s_axi_wready = !q.w_held && !q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_r = q.r;
  assign func_call_pulse = q.func_pulse;
  assign func_call_word = q.func_word;
  assign bus_alignment = q.align;
  assign operating_mode = q.mode;
  assign param_unlocked = unlocked;
  assign nv_save_pulse = q.nv_pulse;
  assign nv_save_index = q.nv_index;
  assign nv_save_data = q.nv_data;

endmodule // serial_terminal_register_bank

/* verification/serial_terminal_register_bank_assertions.sv */
/* Port checker for the serial terminal register bank.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/100ps
module term_regs_chk
  import term_regs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire axil_addr_s s_axi_aw,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire axil_addr_s s_axi_ar,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire axil_rdata_s s_axi_r,
  input wire logic func_call_pulse,
  input wire logic [15:0] func_call_word,
  input wire logic [15:0] operating_mode,
  input wire logic param_unlocked,
  input wire logic nv_save_pulse,
  input wire logic [IDX_W-1:0] nv_save_index
);
  // ==========================================================
  // Last taken word indices
  logic [IDX_W-1:0] rd_q;
  logic [IDX_W-1:0] wr_q;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) rd_q <= s_axi_ar.addr[7:2];
    if (s_axi_awvalid && s_axi_awready) wr_q <= s_axi_aw.addr[7:2];
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Properties
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_r.data[31:16] == 16'h0000)
    else $error("read upper half not zero");
  fill_high_a: assert property ($rose(s_axi_rvalid) && rd_q < 6'h02 |-> s_axi_r.data[15:8] == 8'h00)
    else $error("fill word high byte not zero");
  key_read_a: assert property ($rose(s_axi_rvalid) && rd_q == IDX_UNLOCK_KEY
    |-> s_axi_r.data[15:0] == (param_unlocked ? UNLOCK_CODE : WORD_ZERO)) else $error("key readback wrong");
  func_read_a: assert property ($rose(s_axi_rvalid) && rd_q == IDX_FUNCTION_CALL_WORD
    |-> s_axi_r.data[7:0] == func_call_word[7:0]) else $error("function number readback wrong");
  func_pulse_a: assert property (func_call_pulse |-> wr_q == IDX_FUNCTION_CALL_WORD ##[0:1] s_axi_bvalid)
    else $error("stray function call pulse");
  save_guard_a: assert property (nv_save_pulse |-> param_unlocked && nv_save_index != IDX_UNLOCK_KEY
    && nv_save_index inside {[16:46]}) else $error("parameter save while protected");
  mode_locked_a: assert property (!param_unlocked |=> $stable(operating_mode))
    else $error("mode changed while protected");
  write_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response late");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_r.resp == RESP_OKAY)
    else $error("read answer late or not okay");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_r))
    else $error("read data dropped");
  cover property ($rose(param_unlocked));
  cover property (nv_save_pulse);
  cover property (func_call_pulse);
endmodule // term_regs_chk

bind serial_terminal_register_bank term_regs_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_aw(s_axi_aw),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_ar(s_axi_ar),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_r(s_axi_r),
  .func_call_pulse(func_call_pulse), .func_call_word(func_call_word), .operating_mode(operating_mode),
  .param_unlocked(param_unlocked), .nv_save_pulse(nv_save_pulse), .nv_save_index(nv_save_index));

/* verification/term_host_model.sv */
/* Coupler model: AXI4-Lite master issuing one word access at a time.
   Assumes tasks are entered just after a rising edge. */
`timescale 1ns/100ps
module term_host_model
  import term_regs_pkg::*;
(
  input wire logic aclk,
  output logic awvalid,
  input wire logic awready,
  output axil_addr_s aw,
  output logic wvalid,
  input wire logic wready,
  output axil_wdata_s w,
  input wire logic bvalid,
  output logic bready,
  output logic arvalid,
  input wire logic arready,
  output axil_addr_s ar,
  input wire logic rvalid,
  output logic rready,
  input wire axil_rdata_s r
);
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} <= '0;
    aw <= '0;
    w <= '0;
    ar <= '0;
  end
  // Handshakes are judged mid-cycle, where ready is settled
  task automatic wr(input logic [5:0] i, input logic [15:0] d, input logic [1:0] be);
    logic ta, tw;
    awvalid <= 1'b1;
    aw.addr <= {i, 2'($urandom)};
    wvalid <= 1'b1;
    w <= '{data: {16'($urandom), d}, strb: {2'($urandom), be}};
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while ((awvalid && !ta) || (wvalid && !tw));
    repeat ($urandom_range(2)) @(posedge aclk);
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = bvalid;
      @(posedge aclk);
    end while (!ta);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] i, output logic [31:0] q);
    logic t;
    arvalid <= 1'b1;
    ar.addr <= {i, 2'($urandom)};
    do begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end while (!t);
    arvalid <= 1'b0;
    repeat ($urandom_range(2)) @(posedge aclk);
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      t = rvalid;
      q = r.data;
      @(posedge aclk);
    end while (!t);
    rready <= 1'b0;
  endtask
endmodule // term_host_model

/* verification/serial_terminal_register_bank_tb_top.sv */
/* Self-checking bench for the register bank with a word-level model.
   Assumes the coupler model drives the register bus. */
`timescale 1ns/100ps
module serial_terminal_register_bank_tb_top;
  import term_regs_pkg::*;
  localparam logic [15:0] KIND = 16'h005a; // Arbitrary value
  localparam logic [15:0] VER = 16'h3230;
  localparam logic [15:0] LEN = 16'h0208;
  localparam logic [15:0] CHN = 16'h0002;
  localparam logic [15:0] MINL = 16'h8404;
  localparam logic [7:0] LAY = 8'h13;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, fpulse, unl, spulse;
  logic [1:0] bresp;
  axil_addr_s aw, ar;
  axil_wdata_s w;
  axil_rdata_s r;
  engine_status_s es;
  logic [15:0] fword, align, mode, sdata, key, fc;
  logic [15:0] mem [64];
  logic [5:0] sidx;
  int failures, n_checks, cycles, npulse, nsave, epulse, esave;
  serial_terminal_register_bank #(.TERMINAL_KIND(KIND), .FIRMWARE_VERSION(VER), .SHIFT_REG_LENGTH(LEN),
    .LOGICAL_CHANNEL_COUNT(CHN), .MIN_TRANSFER_LENGTH(MINL), .PAYLOAD_LAYOUT_TYPE(LAY)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_aw(aw),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_w(w), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_ar(ar), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_r(r), .engine_status(es), .func_call_pulse(fpulse), .func_call_word(fword),
    .bus_alignment(align), .operating_mode(mode), .param_unlocked(unl), .nv_save_pulse(spulse),
    .nv_save_index(sidx), .nv_save_data(sdata));
  term_host_model u_host (.aclk(aclk), .awvalid(awvalid), .awready(awready), .aw(aw), .wvalid(wvalid),
    .wready(wready), .w(w), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .ar(ar),
    .rvalid(rvalid), .rready(rready), .r(r));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    npulse += (fpulse === 1'b1);
    nsave += (spulse === 1'b1);
    if (++cycles > 12000) begin
      failures++;
      end_sim();
    end
  end
  // Responses are looked at mid-cycle, before the edge that completes them
  always @(negedge aclk) begin
    if (bvalid === 1'b1 && bready === 1'b1) chk(bresp, RESP_OKAY);
    if (rvalid === 1'b1 && rready === 1'b1) chk(r.resp, RESP_OKAY);
  end
  // ==========================================================
  // Model and helpers
  function automatic logic [15:0] ex(int i);
    case (i)
      0: return {8'h00, es.tx_fill};
      1: return {8'h00, es.rx_fill};
      6: return es.diag;
      7: return {es.func_result, fc[7:0]};
      8: return KIND;
      9: return VER;
      10: return LEN;
      11: return CHN;
      12: return MINL;
      13: return {8'h00, LAY};
      15: return mem[15];
      31: return (key == UNLOCK_CODE) ? UNLOCK_CODE : 16'h0000;
      default: return (i >= 16 && i <= 46) ? mem[i] : 16'h0000;
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int i, input logic [15:0] d, input logic [1:0] be);
    logic [15:0] m;
    u_host.wr(i[5:0], d, be);
    m = (i == 31) ? key : (i == 7) ? fc : mem[i];
    if (be[0]) m[7:0] = d[7:0];
    if (be[1]) m[15:8] = d[15:8];
    if (i == 7) begin
      fc = m;
      epulse++;
    end else if (i == 31) key = m;
    else if (i == 15) mem[i] = m;
    else if (i inside {[16:30], [32:46]} && key == UNLOCK_CODE) begin
      mem[i] = m;
      esave++;
      chk(sidx, i[5:0]);
      chk(sdata, m);
    end
  endtask
  task automatic all_pass(input string name);
    logic [31:0] q;
    es <= {$urandom, 8'($urandom)};
    @(posedge aclk);
    for (int i = 0; i < 64; i++) begin
      u_host.rd(i[5:0], q);
      chk(q, {16'h0000, ex(i)});
    end
    chk(fword, fc);
    chk(align, mem[15]);
    chk(mode, mem[32]);
    chk(unl, key == UNLOCK_CODE);
    chk(npulse, epulse);
    chk(nsave, esave);
    $display("test %s done", name);
    // Key last, so an open pass also writes the mode and user words unlocked
    for (int i = 0; i < 64; i++) if (i != 31) wt(i, 16'($urandom), 2'($urandom_range(1, 3)));
    wt(31, 16'($urandom), 2'($urandom_range(1, 3)));
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    aresetn = 1'b0;
    es = '0;
    void'($urandom(32'hd56b));
    foreach (mem[i]) mem[i] = 16'h0000;
    {key, fc} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    all_pass("reset");
    all_pass("locked");
    wt(31, 16'h0035, 2'b01);
    wt(31, 16'h1200, 2'b10);
    all_pass("unlocked");
    wt(31, 16'h1235, 2'b11);
    wt(31, 16'h1234, 2'b11);
    all_pass("relocked");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (mem[i]) mem[i] = 16'h0000;
    {key, fc} = '0;
    @(posedge aclk);
    all_pass("second reset");
    end_sim();
  end
endmodule // serial_terminal_register_bank_tb_top
